// File: t1ad_alarm_detector.sv
// Purpose: T1/J1 receive alarm detector for frame loss, remote and all-ones alarms
// Assumes: rx marks and in_sync come from the framer on this clock
// Notes:   tallies run over fixed windows; persistence is counted in windows
`timescale 1ns/100ps
`include "t1ad_consts.svh"

module t1ad_alarm_detector #(
  parameter int WIN_CYCLES = `T1AD_WIN_MS * `T1AD_CLK_KHZ
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  t1ad_pkg::t1ad_rx_t rx,
  input  wire logic       in_sync,
  output logic            irq_n
);
  import t1ad_pkg::*;

  logic [31:0] tick_cnt_reg;
  logic [31:0] tick_cnt_next;
  logic        tick;
  t1ad_win_t   win_reg;
  t1ad_win_t   win_next;
  t1ad_win_t   cur;
  logic [2:0]  irq_en_reg;
  logic [2:0]  irq_en_next;
  logic [2:0]  flags_reg;
  logic [2:0]  flags_next;
  logic [2:0]  prev_reg;
  logic [2:0]  status;
  logic [2:0]  changed;
  logic [7:0]  red_decl_reg;
  logic [7:0]  red_decl_next;
  logic [7:0]  red_clr_reg;
  logic [7:0]  red_clr_next;
  logic [7:0]  yel_decl_reg;
  logic [7:0]  yel_decl_next;
  logic [7:0]  yel_clr_reg;
  logic [7:0]  yel_clr_next;
  logic [7:0]  ais_decl_reg;
  logic [7:0]  ais_decl_next;
  logic [7:0]  ais_clr_reg;
  logic [7:0]  ais_clr_next;
  logic [2:0]  mode_reg;
  logic [2:0]  mode_next;
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_data_next;
  logic        irq_n_reg;
  logic        irq_n_next;
  logic        red_decl_ok;
  logic        red_clr_ok;
  logic        yel_decl_raw;
  logic        yel_clr_raw;
  logic        yel_decl_ok;
  logic        yel_clr_ok;
  logic        ais_decl_ok;
  logic        ais_clr_ok;
  logic        red_active;
  logic        yel_active;
  logic        ais_active;

  // saturating tally step; a window never holds 65535 events at T1 rate
  function automatic logic [15:0] sat_inc(input logic [15:0] c, input logic e);
    sat_inc = (e && (c != 16'hFFFF)) ? c + 16'h0001 : c;
  endfunction

  // window timer: tick marks the last cycle of each fixed window
  assign tick          = (tick_cnt_reg == 32'(WIN_CYCLES - 1));
  assign tick_cnt_next = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;

  // tallies including this cycle's bit, so the bit on tick is not lost
  always_comb
  begin
    cur           = win_reg;
    cur.in_seen   = win_reg.in_seen | in_sync;
    cur.out_seen  = win_reg.out_seen | !in_sync;
    if (rx.valid)
    begin
      cur.all_zeros = sat_inc(win_reg.all_zeros, !rx.data);
      cur.slc_ones  = sat_inc(win_reg.slc_ones, rx.ch_bit2 && rx.data);
      cur.dm_ones   = sat_inc(win_reg.dm_ones, rx.y_bit && rx.data);
      cur.f12_zeros = sat_inc(win_reg.f12_zeros, rx.f12_bit && !rx.data);
      cur.dl_zeros  = sat_inc(win_reg.dl_zeros, rx.dl_bit && !rx.data);
      if (rx.dl_bit)
      begin
        cur.dl_shift = {win_reg.dl_shift[14:0], rx.data}; // msb first
        cur.esf_pats = sat_inc(win_reg.esf_pats, cur.dl_shift == `T1AD_ESF_PATTERN);
      end
    end
    win_next          = cur;
    if (tick)
    begin
      win_next          = '0;
      win_next.dl_shift = cur.dl_shift; // pattern may straddle windows
    end
  end

  // window verdicts, only meaningful while tick is high
  assign red_decl_ok = !cur.in_seen;
  assign red_clr_ok  = !cur.out_seen;
  assign ais_decl_ok = cur.all_zeros < `T1AD_AIS_ZEROS_MIN;
  assign ais_clr_ok  = cur.all_zeros > `T1AD_AIS_ZEROS_CLR;

  // yellow criteria by format; plain T1 SF has none here so yellow holds
  always_comb
  begin
    yel_decl_raw = 1'b0;
    case (t1ad_mode_t'(mode_reg))
      T1AD_ESF:   yel_decl_raw = cur.esf_pats > `T1AD_ESF_PAT_MAX;
      T1AD_DM:    yel_decl_raw = cur.dm_ones < `T1AD_DM_ONES_MIN;
      T1AD_SLC96: yel_decl_raw = cur.slc_ones < `T1AD_SLC_ONES_MIN;
      T1AD_J1SF:  yel_decl_raw = cur.f12_zeros < `T1AD_J1SF_ZEROS_MIN;
      T1AD_J1ESF: yel_decl_raw = cur.dl_zeros < `T1AD_J1ESF_ZEROS_MIN;
      default:    yel_decl_raw = 1'b0;
    endcase
    yel_clr_raw = !yel_decl_raw && (t1ad_mode_t'(mode_reg) != T1AD_SF) && (mode_reg < 3'h6);
  end

  // a window that lost sync at any point neither declares nor clears yellow
  assign yel_decl_ok = yel_decl_raw && !cur.out_seen;
  assign yel_clr_ok  = yel_clr_raw && !cur.out_seen;

  // persistence per alarm
  t1ad_persist u_red (
    .clock         (clock),
    .rst           (rst),
    .tick          (tick),
    .declare_ok    (red_decl_ok),
    .clear_ok      (red_clr_ok),
    .declare_count (red_decl_reg),
    .clear_count   (red_clr_reg),
    .active        (red_active)
  );

  t1ad_persist u_yel (
    .clock         (clock),
    .rst           (rst),
    .tick          (tick),
    .declare_ok    (yel_decl_ok),
    .clear_ok      (yel_clr_ok),
    .declare_count (yel_decl_reg),
    .clear_count   (yel_clr_reg),
    .active        (yel_active)
  );

  t1ad_persist u_ais (
    .clock         (clock),
    .rst           (rst),
    .tick          (tick),
    .declare_ok    (ais_decl_ok),
    .clear_ok      (ais_clr_ok),
    .declare_count (ais_decl_reg),
    .clear_count   (ais_clr_reg),
    .active        (ais_active)
  );

  always_comb
  begin
    status                = 3'h0;
    status[`T1AD_BIT_AIS] = ais_active;
    status[`T1AD_BIT_YEL] = yel_active;
    status[`T1AD_BIT_RED] = red_active;
  end
  assign changed = status ^ prev_reg;

  // register writes; a change in the clearing cycle keeps its flag set
  always_comb
  begin
    irq_en_next   = irq_en_reg;
    red_decl_next = red_decl_reg;
    red_clr_next  = red_clr_reg;
    yel_decl_next = yel_decl_reg;
    yel_clr_next  = yel_clr_reg;
    ais_decl_next = ais_decl_reg;
    ais_clr_next  = ais_clr_reg;
    mode_next     = mode_reg;
    flags_next    = flags_reg;
    if (wr_en)
    begin
      case (addr)
        `T1AD_ADDR_IRQ_EN:   irq_en_next   = wr_data[2:0];
        `T1AD_ADDR_FLAGS:    flags_next    = flags_reg & ~wr_data[2:0];
        `T1AD_ADDR_RED_DECL: red_decl_next = wr_data;
        `T1AD_ADDR_RED_CLR:  red_clr_next  = wr_data;
        `T1AD_ADDR_YEL_DECL: yel_decl_next = wr_data;
        `T1AD_ADDR_YEL_CLR:  yel_clr_next  = wr_data;
        `T1AD_ADDR_AIS_DECL: ais_decl_next = wr_data;
        `T1AD_ADDR_AIS_CLR:  ais_clr_next  = wr_data;
        `T1AD_ADDR_MODE:     mode_next     = wr_data[2:0];
        default:             mode_next     = mode_reg;
      endcase
    end
    flags_next = flags_next | changed;
    irq_n_next = ~|(flags_next & irq_en_next);
  end

  // read mux; unmapped addresses and reserved bits read zero
  always_comb
  begin
    rd_data_next = 8'h00;
    if (rd_en)
    begin
      case (addr)
        `T1AD_ADDR_STATE:    rd_data_next = {5'h00, status};
        `T1AD_ADDR_IRQ_EN:   rd_data_next = {5'h00, irq_en_reg};
        `T1AD_ADDR_FLAGS:    rd_data_next = {5'h00, flags_reg};
        `T1AD_ADDR_RED_DECL: rd_data_next = red_decl_reg;
        `T1AD_ADDR_RED_CLR:  rd_data_next = red_clr_reg;
        `T1AD_ADDR_YEL_DECL: rd_data_next = yel_decl_reg;
        `T1AD_ADDR_YEL_CLR:  rd_data_next = yel_clr_reg;
        `T1AD_ADDR_AIS_DECL: rd_data_next = ais_decl_reg;
        `T1AD_ADDR_AIS_CLR:  rd_data_next = ais_clr_reg;
        `T1AD_ADDR_MODE:     rd_data_next = {5'h00, mode_reg};
        default:             rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      win_reg      <= '0;
      irq_en_reg   <= 3'h0;
      flags_reg    <= 3'h0;
      prev_reg     <= 3'h0;
      red_decl_reg <= `T1AD_LIMIT_RST;
      red_clr_reg  <= `T1AD_LIMIT_RST;
      yel_decl_reg <= `T1AD_LIMIT_RST;
      yel_clr_reg  <= `T1AD_LIMIT_RST;
      ais_decl_reg <= `T1AD_LIMIT_RST;
      ais_clr_reg  <= `T1AD_LIMIT_RST;
      mode_reg     <= `T1AD_MODE_RST;
      rd_data_reg  <= 8'h00;
      irq_n_reg    <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_next;
      win_reg      <= win_next;
      irq_en_reg   <= irq_en_next;
      flags_reg    <= flags_next;
      prev_reg     <= status;
      red_decl_reg <= red_decl_next;
      red_clr_reg  <= red_clr_next;
      yel_decl_reg <= yel_decl_next;
      yel_clr_reg  <= yel_clr_next;
      ais_decl_reg <= ais_decl_next;
      ais_clr_reg  <= ais_clr_next;
      mode_reg     <= mode_next;
      rd_data_reg  <= rd_data_next;
      irq_n_reg    <= irq_n_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign irq_n   = irq_n_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  AST_RED_WINDOW: assert property (
    tick && !in_sync && !win_reg.in_seen |-> red_decl_ok && !red_clr_ok)
    else $error("fully out-of-sync window not counted toward frame loss");
  AST_RED_CLEAR_WINDOW: assert property (
    tick && in_sync && !win_reg.out_seen |-> red_clr_ok && !red_decl_ok)
    else $error("fully in-sync window not counted toward clear");
  AST_SLC_DECL: assert property (
    tick && mode_reg == T1AD_SLC96 && !cur.out_seen |->
      yel_decl_ok == (cur.slc_ones < `T1AD_SLC_ONES_MIN))
    else $error("slc-96 yellow verdict wrong");
  AST_ESF_DECL: assert property (
    tick && mode_reg == T1AD_ESF && !cur.out_seen |->
      yel_decl_ok == (cur.esf_pats > `T1AD_ESF_PAT_MAX))
    else $error("esf yellow verdict wrong");
  AST_DM_DECL: assert property (
    tick && mode_reg == T1AD_DM && !cur.out_seen |->
      yel_decl_ok == (cur.dm_ones < `T1AD_DM_ONES_MIN))
    else $error("dm yellow verdict wrong");
  AST_J1SF_DECL: assert property (
    tick && mode_reg == T1AD_J1SF && !cur.out_seen |->
      yel_decl_ok == (cur.f12_zeros < `T1AD_J1SF_ZEROS_MIN))
    else $error("j1 sf yellow verdict wrong");
  AST_J1SF_CLEAR: assert property (
    tick && mode_reg == T1AD_J1SF && !cur.out_seen |-> yel_clr_ok == !yel_decl_ok)
    else $error("j1 sf yellow clear verdict wrong");
  AST_J1ESF_DECL: assert property (
    tick && mode_reg == T1AD_J1ESF && !cur.out_seen |->
      yel_decl_ok == (cur.dl_zeros < `T1AD_J1ESF_ZEROS_MIN))
    else $error("j1 esf yellow verdict wrong");
  AST_AIS_DECL: assert property (
    tick && cur.all_zeros <= `T1AD_AIS_ZEROS_CLR |-> ais_decl_ok && !ais_clr_ok)
    else $error("all-ones declare verdict wrong");
  AST_AIS_CLEAR: assert property (
    tick && cur.all_zeros >= `T1AD_AIS_ZEROS_MIN |-> ais_clr_ok && !ais_decl_ok)
    else $error("all-ones clear verdict wrong");
  AST_YEL_NO_SYNC: assert property (
    !in_sync |=> $stable(yel_active) [*2])
    else $error("yellow moved right after loss of sync");
  AST_FLAG_ON_CHANGE: assert property (
    changed != 3'h0 |=> (flags_reg & $past(changed)) == $past(changed) && !irq_n_reg == |(flags_reg & irq_en_reg))
    else $error("status change did not raise its flag");
  AST_READ_NEXT: assert property (
    rd_en && addr == `T1AD_ADDR_FLAGS |=> rd_data == {5'h00, $past(flags_reg)} ##1 rd_data == 8'h00 || $past(rd_en))
    else $error("flag read data not in the following cycle");

  COV_RED_UP: cover property (!red_active ##1 red_active);
  COV_YEL_UP: cover property (!yel_active ##1 yel_active);
  COV_AIS_DOWN: cover property (ais_active ##1 !ais_active);
  COV_IRQ: cover property (irq_n_reg ##1 !irq_n_reg);

endmodule

// File: t1ad_alarm_detector_tb.sv
// Purpose: self-checking bench for the receive alarm detector
// Assumes: windows shortened to W cycles; stimulus follows a window grid counted from reset
// Notes:   sync changes land a few cycles before each boundary, so the window before is
//          mixed and neither declares nor clears red or yellow; bits are sent mid-window, clear of the edges
`timescale 1ns/100ps
`include "t1ad_consts.svh"

module t1ad_alarm_detector_tb;
  import t1ad_pkg::*;

  localparam int W = 400;
  // yellow table per mode: marks {dl,ch2,y,f12}, data pattern, declare and clear bit counts
  localparam logic [2:0]  YM  [5] = '{3'h3, 3'h1, 3'h2, 3'h4, 3'h5};
  localparam logic [3:0]  YMK [5] = '{4'h4, 4'h8, 4'h2, 4'h1, 4'h8};
  localparam logic [15:0] YP  [5] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'h0000, 16'h0000};
  localparam int          YD  [5] = '{76, 128, 3, 3, 2};
  localparam int          YC  [5] = '{77, 112, 4, 4, 3};

  logic       clock;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rd_data;
  t1ad_rx_t   rx;
  logic       in_sync;
  logic       irq_n;
  int         err_count;
  int         num_checks;
  int         seed;
  int         cyc;
  logic [7:0] lim [6];
  logic [7:0] d;
  logic [7:0] r;

  t1ad_alarm_detector #(.WIN_CYCLES(W)) dut (
    .clock   (clock),
    .rst     (rst),
    .addr    (addr),
    .wr_data (wr_data),
    .wr_en   (wr_en),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .rx      (rx),
    .in_sync (in_sync),
    .irq_n   (irq_n)
  );

  // 200 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // window grid as seen by the bench, restarted by reset
  always @(posedge clock)
  begin
    if (rst)
      cyc <= 0;
    else
      cyc <= cyc + 1;
  end

  function automatic int rnd(input int m);
    return ($random(seed) & 32'h7FFF_FFFF) % m;
  endfunction

  // bits that read back after a write; everything else reads 0
  function automatic logic [7:0] wmask(input logic [7:0] a);
    if (a == `T1AD_ADDR_IRQ_EN || a == `T1AD_ADDR_MODE)
      return 8'h07;
    if (a >= `T1AD_ADDR_RED_DECL && a <= `T1AD_ADDR_AIS_CLR)
      return 8'hFF;
    return 8'h00;
  endfunction

  function automatic logic [7:0] rst_val(input logic [7:0] a);
    if (a >= `T1AD_ADDR_RED_DECL && a <= `T1AD_ADDR_AIS_CLR)
      return `T1AD_LIMIT_RST;
    if (a == `T1AD_ADDR_MODE)
      return {5'h00, `T1AD_MODE_RST};
    return 8'h00;
  endfunction

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one-cycle strobes with an idle edge after, so strobes never get two drives in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en   <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(posedge clock);
    v = rd_data;
  endtask

  // one window: sync level from just before its start, n marked bits from a quarter in
  task automatic win(input logic s, input int n, input logic [3:0] mk, input logic [15:0] pat);
    do @(posedge clock); while (cyc % W != W - 3);
    in_sync <= s;
    repeat (W / 4) @(posedge clock);
    for (int i = 0; i < n; i++)
    begin
      rx <= {1'b1, pat[15 - (i % 16)], mk};
      @(posedge clock);
    end
    rx <= '0;
    @(posedge clock);
  endtask

  // nl-1 qualifying windows leave status alone, the nl-th flips it, flags and irq follow
  task automatic trial(input int b, input logic [7:0] nl, input logic s, input int n,
                       input logic [3:0] mk, input logic [15:0] pat, input logic exp);
    wr(`T1AD_ADDR_FLAGS, 8'hFF);
    repeat (nl) win(s, n, mk, pat);
    rd(`T1AD_ADDR_STATE, d);
    chk1("status before limit", ~exp, d[b]);
    rd(`T1AD_ADDR_FLAGS, d);
    chk1("flag before change", 1'b0, d[b]);
    win(s, n, mk, pat);
    rd(`T1AD_ADDR_STATE, d);
    chk1("status at limit", exp, d[b]);
    rd(`T1AD_ADDR_FLAGS, d);
    chk1("flag after change", 1'b1, d[b]);
    wr(`T1AD_ADDR_IRQ_EN, 8'h01 << b);
    @(posedge clock);
    chk1("irq_n enabled", 1'b0, irq_n);
    wr(`T1AD_ADDR_FLAGS, 8'h01 << b);
    @(posedge clock);
    chk1("irq_n after clear", 1'b1, irq_n);
    rd(`T1AD_ADDR_FLAGS, d);
    chk1("flag after clear", 1'b0, d[b]);
    wr(`T1AD_ADDR_IRQ_EN, 8'h00);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a full run takes far fewer cycles than this span of about 200 windows
  initial
  begin
    repeat (200 * W) @(posedge clock);
    err_count++;
    $display("[FAIL] watchdog expected end seen timeout");
    end_of_test;
  end

  initial
  begin
    seed       = 22603;
    err_count  = 0;
    num_checks = 0;
    rst        = 1'b1;
    addr       = 8'h00;
    wr_data    = 8'h00;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    rx         = '0;
    in_sync    = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // reset values over the map plus one unmapped place, before any window ends
    for (int a = 8'hB9; a <= 8'hC2; a++)
    begin
      rd(a[7:0], d);
      chk8("reset value", rst_val(a[7:0]), d);
    end
    rd(`T1AD_ADDR_MODE, d);
    chk8("reset mode", rst_val(`T1AD_ADDR_MODE), d);
    @(posedge clock);
    chk8("rd_data after read", 8'h00, rd_data);
    chk1("irq_n idle", 1'b1, irq_n);
    // random writes everywhere: read-only, reserved and unmapped bits stay 0
    for (int a = 8'hB9; a <= 8'hCF; a++)
    begin
      r = 8'(rnd(256));
      wr(a[7:0], r);
      rd(a[7:0], d);
      chk8("write readback", r & wmask(a[7:0]), d);
    end
    // mode 0 keeps yellow still while the all-ones alarm is exercised
    wr(`T1AD_ADDR_MODE, 8'h00);
    wr(`T1AD_ADDR_IRQ_EN, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      lim[i] = 8'(1 + rnd(3));
      wr(8'(`T1AD_ADDR_RED_DECL + i), lim[i]);
    end
    repeat (4) win(1'b1, 0, 4'h0, 16'h0000);
    trial(0, lim[5], 1'b1, 61, 4'h0, 16'h0000, 1'b0);
    trial(0, lim[4], 1'b1, 60, 4'h0, 16'h0000, 1'b1);
    trial(0, lim[5], 1'b1, 61 + rnd(40), 4'h0, 16'h0000, 1'b0);
    trial(0, lim[4], 1'b1, rnd(61), 4'h0, 16'h0000, 1'b1);
    rd(`T1AD_ADDR_STATE, d);
    chk1("yellow still in mode 0", 1'b0, d[`T1AD_BIT_YEL]);
    // each yellow mode: one clearing window resets any run, then declare and clear
    for (int i = 0; i < 5; i++)
    begin
      wr(`T1AD_ADDR_MODE, {5'h00, YM[i]});
      win(1'b1, YC[i], YMK[i], YP[i]);
      trial(1, lim[2], 1'b1, YD[i], YMK[i], YP[i], 1'b1);
      trial(1, lim[3], 1'b1, YC[i], YMK[i], YP[i], 1'b0);
    end
    // out of sync: yellow must hold although the DM count would declare
    wr(`T1AD_ADDR_MODE, 8'h02);
    win(1'b1, 4, 4'h2, 16'hFFFF);
    repeat (4) win(1'b0, 0, 4'h0, 16'h0000);
    rd(`T1AD_ADDR_STATE, d);
    chk1("yellow out of sync", 1'b0, d[`T1AD_BIT_YEL]);
    trial(2, lim[1], 1'b1, 0, 4'h0, 16'h0000, 1'b0);
    trial(2, lim[0], 1'b0, 0, 4'h0, 16'h0000, 1'b1);
    end_of_test;
  end
endmodule

// File: t1ad_consts.svh
// Purpose: named constants of the receive alarm detector
// Assumes: included by bare name wherever a constant is needed
// Notes:   definitions only
`ifndef T1AD_CONSTS_SVH
`define T1AD_CONSTS_SVH

// register offsets
`define T1AD_ADDR_STATE      8'hB9
`define T1AD_ADDR_IRQ_EN     8'hBA
`define T1AD_ADDR_FLAGS      8'hBB
`define T1AD_ADDR_RED_DECL   8'hBC
`define T1AD_ADDR_RED_CLR    8'hBD
`define T1AD_ADDR_YEL_DECL   8'hBE
`define T1AD_ADDR_YEL_CLR    8'hBF
`define T1AD_ADDR_AIS_DECL   8'hC0
`define T1AD_ADDR_AIS_CLR    8'hC1
`define T1AD_ADDR_MODE       8'hCF

// bit positions inside state, enable and flag registers
`define T1AD_BIT_AIS         0
`define T1AD_BIT_YEL         1
`define T1AD_BIT_RED         2

// reset values
`define T1AD_LIMIT_RST       8'h01
`define T1AD_MODE_RST        3'h1

// window timing: figure in ms and clock rate in kHz
`define T1AD_WIN_MS          40
`define T1AD_CLK_KHZ         200000

// per-window thresholds
`define T1AD_SLC_ONES_MIN    16'h004D
`define T1AD_ESF_PAT_MAX     16'h0007
`define T1AD_ESF_PATTERN     16'hFF00
`define T1AD_DM_ONES_MIN     16'h0004
`define T1AD_J1SF_ZEROS_MIN  16'h0004
`define T1AD_J1ESF_ZEROS_MIN 16'h0003
`define T1AD_AIS_ZEROS_MIN   16'h003D
`define T1AD_AIS_ZEROS_CLR   16'h003C

`endif

// File: t1ad_persist.sv
// Purpose: declare/clear persistence of one alarm over whole windows
// Assumes: tick is a one-cycle pulse at each window end
// Notes:   a limit of zero acts like one
`timescale 1ns/100ps
`include "t1ad_consts.svh"

module t1ad_persist (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       declare_ok,
  input  wire logic       clear_ok,
  input  wire logic [7:0] declare_count,
  input  wire logic [7:0] clear_count,
  output logic            active
);
  import t1ad_pkg::*;

  logic       state_reg;
  logic       state_next;
  logic [7:0] run_reg;
  logic [7:0] run_next;

  // true when this window completes the required run
  function automatic logic reached(input logic [7:0] run, input logic [7:0] lim);
    reached = ({1'b0, run} + 9'h001) >= {1'b0, lim};
  endfunction

  // count consecutive qualifying windows; any other window restarts the run
  always_comb
  begin
    state_next = state_reg;
    run_next   = run_reg;
    if (tick)
    begin
      if (!state_reg && declare_ok)
      begin
        if (reached(run_reg, declare_count))
        begin
          state_next = 1'b1;
          run_next   = 8'h00;
        end
        else
          run_next = run_reg + 8'h01;
      end
      else if (state_reg && clear_ok)
      begin
        if (reached(run_reg, clear_count))
        begin
          state_next = 1'b0;
          run_next   = 8'h00;
        end
        else
          run_next = run_reg + 8'h01;
      end
      else
        run_next = 8'h00;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= 1'b0;
      run_reg   <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      run_reg   <= run_next;
    end
  end

  assign active = state_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  AST_PERSIST_DECLARE: assert property (
    tick && !state_reg && declare_ok && reached(run_reg, declare_count) |=> state_reg)
    else $error("alarm not declared after full declare run");

  AST_PERSIST_CLEAR: assert property (
    tick && state_reg && clear_ok && reached(run_reg, clear_count) |=> !state_reg)
    else $error("alarm not cleared after full clear run");

  AST_PERSIST_HOLD: assert property (
    !tick |=> $stable(state_reg))
    else $error("alarm state moved outside a window end");

endmodule

// File: t1ad_pkg.sv
// Purpose: types of the receive alarm detector
// Assumes: nothing
// Notes:   framing mode codes follow the enum order
package t1ad_pkg;

  // receive framing format
  typedef enum logic [2:0] {
    T1AD_SF,
    T1AD_ESF,
    T1AD_DM,
    T1AD_SLC96,
    T1AD_J1SF,
    T1AD_J1ESF
  } t1ad_mode_t;

  // one received bit with its position marks, from the framer
  typedef struct packed {
    logic valid;
    logic data;
    logic dl_bit;
    logic ch_bit2;
    logic y_bit;
    logic f12_bit;
  } t1ad_rx_t;

  // per-window tallies
  typedef struct packed {
    logic [15:0] slc_ones;
    logic [15:0] esf_pats;
    logic [15:0] dm_ones;
    logic [15:0] f12_zeros;
    logic [15:0] dl_zeros;
    logic [15:0] all_zeros;
    logic [15:0] dl_shift;
    logic        in_seen;
    logic        out_seen;
  } t1ad_win_t;

endpackage
